/* File: include/crg_pkg.sv */
// Package with constants, types and register layout of the CPU register set.
package crg_pkg;
    localparam int DATA_W = 16;
    localparam int NUM_REGS = 16;
    localparam logic [3:0] IDX_PROGRAM_COUNTER = 4'h0;
    localparam logic [3:0] IDX_STACK_POINTER = 4'h1;
    localparam logic [3:0] IDX_STATUS_REGISTER = 4'h2;
    localparam logic [3:0] IDX_CONSTANT_SECOND = 4'h3;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] ALIGN_MASK = 16'hFFFE;
    // Status register bit positions.
    localparam int SR_CARRY = 0;
    localparam int SR_ZERO = 1;
    localparam int SR_NEGATIVE = 2;
    localparam int SR_GIE = 3;
    localparam int SR_CPU_OFF = 4;
    localparam int SR_OSC_OFF = 5;
    localparam int SR_CLK_LO = 6;
    localparam int SR_CLK_HI = 7;
    localparam int SR_OVERFLOW = 8;
    localparam logic [15:0] SR_IMPL_MASK = 16'h01FF;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Special function region byte offsets.
    localparam logic [15:0] SFR_IE_FIRST = 16'h0000;
    localparam logic [15:0] SFR_IE_SECOND = 16'h0001;
    localparam logic [15:0] SFR_IFG_FIRST = 16'h0002;
    localparam logic [15:0] SFR_IFG_SECOND = 16'h0003;
    localparam logic [15:0] SFR_ME_FIRST = 16'h0004;
    localparam logic [15:0] SFR_ME_SECOND = 16'h0005;
    localparam logic [7:0] SFR_RESET = 8'h00;
    // Constant source values.
    localparam logic [15:0] CONST_ZERO = 16'h0000;
    localparam logic [15:0] CONST_ONE = 16'h0001;
    localparam logic [15:0] CONST_TWO = 16'h0002;
    localparam logic [15:0] CONST_FOUR = 16'h0004;
    localparam logic [15:0] CONST_EIGHT = 16'h0008;
    localparam logic [15:0] CONST_ALL_ONES = 16'hFFFF;

    // Arithmetic operation selector for flag generation.
    typedef enum logic [2:0] {
        CRG_OP_NONE, CRG_OP_ADD, CRG_OP_ADDC, CRG_OP_SUB, CRG_OP_SUBC, CRG_OP_CMP, CRG_OP_LOGIC
    } crg_op_t;

    // Stack operation selector.
    typedef enum logic [1:0] {
        CRG_STK_NONE, CRG_STK_PUSH, CRG_STK_POP
    } crg_stk_t;

    // Request from the instruction sequencer.
    typedef struct packed {
        logic wr_en;
        logic [3:0] wr_idx;
        logic [15:0] wr_data;
        logic [3:0] rd_idx;
        logic [1:0] source_mode_bits;
        logic pc_advance;
        logic [2:0] pc_len_words;
        crg_op_t op;
        logic byte_op;
        logic [15:0] op_a;
        logic [15:0] op_b;
        logic carry_from_not_zero;
        crg_stk_t stk;
        logic irq_enter;
        logic return_from_interrupt;
    } crg_req_t;

    // Byte-wide memory bus to the special function region.
    typedef struct packed {
        logic en;
        logic we;
        logic byte_access;
        logic [15:0] addr;
        logic [7:0] wdata;
    } crg_bus_t;

    // Block state.
    typedef struct packed {
        logic [NUM_REGS-1:0][15:0] regs;
        logic [5:0][7:0] special_function_region;
        logic [15:0] rd_data;
        logic [15:0] stack_addr;
        logic [15:0] result;
        logic [7:0] bus_rdata;
        logic bus_err;
        logic cpu_halted;
        logic osc_stopped;
    } crg_state_t;
endpackage : crg_pkg

/* File: rtl/crg_core.sv */
// CPU register set, status flags, low-power bits and special function registers.
module crg_core (
    input wire logic clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input crg_pkg::crg_req_t req, // Request from the instruction sequencer.
    input crg_pkg::crg_bus_t bus, // Byte bus access to the special function region.
    input wire logic nmi, // Non-maskable interrupt request.
    input wire logic [7:0] irq_ext, // External interrupt sources, one per flag bit.
    input wire logic [7:0] irq_ext_pin, // Same external sources seen on pins.
    output logic [15:0] rd_data, // Registered read port of the register file.
    output logic [15:0] program_counter, // Program counter.
    output logic [15:0] stack_pointer, // Stack pointer.
    output logic [15:0] status_register, // Status register.
    output logic [15:0] stack_addr, // Memory address of the current push or pop.
    output logic [15:0] alu_result, // Result of the last flag-setting operation.
    output logic [7:0] bus_rdata, // Read data of the special function region.
    output logic bus_err, // Word or unimplemented access below 0x0010 seen last cycle.
    output logic [1:0] clockgen_sel, // Clock generator activity state.
    output logic cpu_halted, // Program execution stopped.
    output logic osc_stopped, // Oscillator and all activity stopped.
    output logic irq_pending // Maskable or non-maskable interrupt to take.
);
    import crg_pkg::*;

    crg_state_t s_q;
    crg_state_t s_d;
    logic [7:0] pin_meta_q;
    logic [7:0] pin_sync_q;

    // Constant source value from the register and mode bits.
    function automatic logic [15:0] const_value(input logic [3:0] idx, input logic [1:0] mode);
        logic [15:0] v;
        v = CONST_ZERO;
        if (idx == IDX_STATUS_REGISTER) begin
            unique case (mode)
                2'h2: v = CONST_FOUR;
                2'h3: v = CONST_EIGHT;
                default: v = CONST_ZERO;
            endcase
        end else begin
            unique case (mode)
                2'h0: v = CONST_ZERO;
                2'h1: v = CONST_ONE;
                2'h2: v = CONST_TWO;
                default: v = CONST_ALL_ONES;
            endcase
        end
        return v;
    endfunction : const_value

    // Returns true when the byte address is one of the six implemented locations.
    function automatic logic sfr_hit(input logic [15:0] addr);
        return addr <= SFR_ME_SECOND;
    endfunction : sfr_hit

    // Two-flop synchroniser for the pin copies of the interrupt sources.
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta_q <= 8'h00;
            pin_sync_q <= 8'h00;
        end else begin
            pin_meta_q <= irq_ext_pin;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Next-state logic of the whole block.
    always_comb begin
        logic [16:0] sum;
        logic [15:0] b_eff;
        logic cin;
        logic is_sub;
        logic msb_a;
        logic msb_b;
        logic msb_r;
        logic cout;
        logic [15:0] res;
        logic [15:0] sr;
        logic [15:0] sp;
        logic [7:0] enabled;
        logic wake_mask;
        logic [2:0] idx;
        sum = 17'h00000;
        b_eff = 16'h0000;
        cin = 1'b0;
        is_sub = 1'b0;
        msb_a = 1'b0;
        msb_b = 1'b0;
        msb_r = 1'b0;
        cout = 1'b0;
        res = 16'h0000;
        idx = 3'h0;
        enabled = 8'h00;
        wake_mask = 1'b0;
        s_d = s_q;
        sr = s_q.regs[IDX_STATUS_REGISTER];
        sp = s_q.regs[IDX_STACK_POINTER];
        s_d.bus_err = 1'b0;

        // Read port; constant sources replace registers 2 and 3 in constant mode.
        if ((req.rd_idx == IDX_CONSTANT_SECOND) ||
            (req.rd_idx == IDX_STATUS_REGISTER && req.source_mode_bits[1])) begin
            s_d.rd_data = const_value(req.rd_idx, req.source_mode_bits);
        end else begin
            s_d.rd_data = s_q.regs[req.rd_idx];
        end

        // Flag generation for arithmetic and logic operations.
        if (req.op != CRG_OP_NONE) begin
            is_sub = req.op inside {CRG_OP_SUB, CRG_OP_SUBC, CRG_OP_CMP};
            b_eff = is_sub ? ~req.op_b : req.op_b;
            unique case (req.op)
                CRG_OP_ADDC, CRG_OP_SUBC: cin = sr[SR_CARRY];
                CRG_OP_SUB, CRG_OP_CMP: cin = 1'b1;
                default: cin = 1'b0;
            endcase
            if (req.byte_op) begin
                sum = {8'h00, {1'b0, req.op_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin}};
                res = {8'h00, sum[7:0]};
                cout = sum[8];
                msb_a = req.op_a[7];
                msb_b = b_eff[7];
                msb_r = sum[7];
            end else begin
                sum = {1'b0, req.op_a} + {1'b0, b_eff} + {16'h0000, cin};
                res = sum[15:0];
                cout = sum[16];
                msb_a = req.op_a[15];
                msb_b = b_eff[15];
                msb_r = sum[15];
            end
            if (req.op == CRG_OP_LOGIC) begin
                res = req.byte_op ? {8'h00, req.op_a[7:0]} : req.op_a;
                msb_r = req.byte_op ? req.op_a[7] : req.op_a[15];
                sr[SR_OVERFLOW] = 1'b0;
                cout = 1'b0;
            end else begin
                // Inverted second operand makes both add and subtract a same-sign test.
                sr[SR_OVERFLOW] = (msb_a == msb_b) && (msb_r != msb_a);
            end
            sr[SR_NEGATIVE] = msb_r;
            sr[SR_ZERO] = (res == 16'h0000);
            sr[SR_CARRY] = req.carry_from_not_zero ? (res != 16'h0000) : cout;
            s_d.result = res;
        end // Flags otherwise hold.

        // General register write, status writes keep unimplemented bits zero.
        if (req.wr_en && req.wr_idx != IDX_CONSTANT_SECOND) begin
            if (req.wr_idx == IDX_STATUS_REGISTER) begin
                sr = req.wr_data & SR_IMPL_MASK;
            end else if (req.wr_idx != IDX_STACK_POINTER) begin
                s_d.regs[req.wr_idx] = req.wr_data;
            end
        end

        // Interrupt entry clears the enable, return sets it.
        if (req.irq_enter) begin
            sr[SR_GIE] = 1'b0;
            sr[SR_CPU_OFF] = 1'b0;
            sr[SR_OSC_OFF] = 1'b0;
        end else if (req.return_from_interrupt) begin
            sr[SR_GIE] = 1'b1;
        end

        // Stack pointer: predecrement push, postincrement pop, written value wins.
        s_d.stack_addr = sp;
        unique case (req.stk)
            CRG_STK_PUSH: begin
                sp = sp - WORD_STEP;
                s_d.stack_addr = sp;
            end
            CRG_STK_POP: begin
                sp = sp + WORD_STEP;
            end
            default: ;
        endcase
        if (req.wr_en && req.wr_idx == IDX_STACK_POINTER) begin
            sp = req.wr_data;
        end
        s_d.regs[IDX_STACK_POINTER] = sp & ALIGN_MASK;

        // Program counter advance by the instruction length in words.
        if (req.pc_advance && !(req.wr_en && req.wr_idx == IDX_PROGRAM_COUNTER) &&
            !s_q.cpu_halted) begin
            s_d.regs[IDX_PROGRAM_COUNTER] = s_q.regs[IDX_PROGRAM_COUNTER] +
                {12'h000, req.pc_len_words, 1'b0};
        end
        s_d.regs[IDX_PROGRAM_COUNTER] = s_d.regs[IDX_PROGRAM_COUNTER] & ALIGN_MASK;

        // Special function region: byte accesses to offsets zero to five only.
        s_d.bus_rdata = 8'h00;
        if (bus.en) begin
            if (!bus.byte_access || !sfr_hit(bus.addr)) begin
                s_d.bus_err = bus.addr <= 16'h000F;
            end else begin
                idx = bus.addr[2:0];
                s_d.bus_rdata = s_q.special_function_region[idx];
                if (bus.we) begin
                    s_d.special_function_region[idx] = bus.wdata;
                end
            end
        end
        // Flag sets from sources win over a clearing write in the same cycle.
        s_d.special_function_region[SFR_IFG_FIRST[2:0]] = s_d.special_function_region[SFR_IFG_FIRST[2:0]] | irq_ext | pin_sync_q;

        // Low-power state and wake-up.
        enabled = s_q.special_function_region[SFR_IFG_FIRST[2:0]] & s_q.special_function_region[SFR_IE_FIRST[2:0]];
        wake_mask = (enabled != 8'h00) && sr[SR_GIE];
        if (s_q.osc_stopped && (wake_mask || nmi)) begin
            sr[SR_OSC_OFF] = 1'b0;
            sr[SR_CPU_OFF] = 1'b0;
        end else if (s_q.cpu_halted && !s_q.osc_stopped && (wake_mask || nmi)) begin
            sr[SR_CPU_OFF] = 1'b0;
        end
        s_d.regs[IDX_STATUS_REGISTER] = sr & SR_IMPL_MASK;
        s_d.osc_stopped = sr[SR_OSC_OFF];
        s_d.cpu_halted = sr[SR_CPU_OFF] | sr[SR_OSC_OFF];
        s_d.regs[IDX_CONSTANT_SECOND] = REG_RESET;
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Pending maskable interrupt needs the global enable; the nmi bypasses it.
    logic irq_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= nmi || (((s_d.special_function_region[SFR_IFG_FIRST[2:0]] & s_d.special_function_region[SFR_IE_FIRST[2:0]]) != 8'h00)
                && s_d.regs[IDX_STATUS_REGISTER][SR_GIE]);
        end
    end

    // Outputs straight from the state register, irq_pending from irq_q.
    assign rd_data = s_q.rd_data;
    assign program_counter = s_q.regs[IDX_PROGRAM_COUNTER];
    assign stack_pointer = s_q.regs[IDX_STACK_POINTER];
    assign status_register = s_q.regs[IDX_STATUS_REGISTER];
    assign stack_addr = s_q.stack_addr;
    assign alu_result = s_q.result;
    assign bus_rdata = s_q.bus_rdata;
    assign bus_err = s_q.bus_err;
    assign clockgen_sel = s_q.regs[IDX_STATUS_REGISTER][SR_CLK_HI:SR_CLK_LO];
    assign cpu_halted = s_q.cpu_halted;
    assign osc_stopped = s_q.osc_stopped;
    assign irq_pending = irq_q;
endmodule : crg_core

/* File: verification/crg_core_properties.sv */
// Concurrent checks on the ports of the register set core.
module crg_core_properties (
    input wire logic clk, // Clock.
    input wire logic rst, // Reset.
    input crg_pkg::crg_req_t req, // Request.
    input crg_pkg::crg_bus_t bus, // Byte bus.
    input logic [15:0] program_counter, // Counter.
    input logic [15:0] stack_pointer, // Stack pointer.
    input logic [15:0] status_register, // Status word.
    input logic [15:0] stack_addr, // Stack address.
    input logic [15:0] alu_result, // Result.
    input logic bus_err // Bus error.
);
    import crg_pkg::*;
    // Requests that rewrite the status word or the counter directly.
    wire sr_wr = req.wr_en && req.wr_idx == IDX_STATUS_REGISTER;
    wire pc_wr = req.wr_en && req.wr_idx == IDX_PROGRAM_COUNTER;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst);
    // Each property but p_align ties an output to the request that caused it.
    property p_align;
        program_counter[0] == 1'b0 && stack_pointer[0] == 1'b0;
    endproperty
    a_align: assert property (p_align) else $error("Odd pointer.");
    property p_push;
        req.stk == CRG_STK_PUSH && !req.wr_en |=>
            stack_pointer == $past(stack_pointer) - 16'h0002 && stack_addr == stack_pointer;
    endproperty
    a_push: assert property (p_push) else $error("Bad push.");
    property p_pop_self;
        req.stk == CRG_STK_POP && req.wr_en && req.wr_idx == IDX_STACK_POINTER |=>
            stack_pointer == ($past(req.wr_data) & ALIGN_MASK);
    endproperty
    a_pop_self: assert property (p_pop_self) else $error("Bad pop.");
    property p_pc_step;
        req.pc_advance && !pc_wr && status_register[5:4] == 2'b00 && !req.irq_enter |=>
            program_counter == $past(program_counter) + {12'h000, $past(req.pc_len_words), 1'b0};
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("Bad step.");
    property p_flag_hold;
        req.op == CRG_OP_NONE && !sr_wr && !req.return_from_interrupt |=>
            $stable(status_register & 16'h0107);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("Flags moved.");
    property p_word_nz;
        req.op == CRG_OP_ADD && !req.byte_op && !sr_wr |=>
            status_register[SR_NEGATIVE] == alu_result[15] &&
            status_register[SR_ZERO] == (alu_result == 16'h0000);
    endproperty
    a_word_nz: assert property (p_word_nz) else $error("Bad N or Z.");
    property p_add_ovf;
        req.op == CRG_OP_ADD && !req.byte_op && !sr_wr |=>
            status_register[SR_OVERFLOW] == ($past(req.op_a[15]) == $past(req.op_b[15]) &&
            alu_result[15] != $past(req.op_a[15]));
    endproperty
    a_add_ovf: assert property (p_add_ovf) else $error("Bad V.");
    property p_irq_gie;
        req.irq_enter && !sr_wr |=> !status_register[SR_GIE];
    endproperty
    a_irq_gie: assert property (p_irq_gie) else $error("Enable kept.");
    property p_sfr_err;
        bus.en && bus.addr < 16'h0010 && (!bus.byte_access || bus.addr > 16'h0005) |=> bus_err;
    endproperty
    a_sfr_err: assert property (p_sfr_err) else $error("No bus error.");
    // Main scenarios seen.
    c_push: cover property (req.stk == CRG_STK_PUSH);
    c_err: cover property (bus.en ##1 bus_err);
    c_ovf: cover property (req.op == CRG_OP_ADD ##1 status_register[SR_OVERFLOW]);
endmodule : crg_core_properties

bind crg_core crg_core_properties i_crg_core_properties (.*);

/* File: verification/crg_seq_model.sv */
// Model of the instruction sequencer and byte bus master.
module crg_seq_model (
    input wire logic clk, // Clock.
    input logic [7:0] bus_rdata, // Byte read data.
    input logic bus_err, // Bus error.
    output crg_pkg::crg_req_t req, // Request.
    output crg_pkg::crg_bus_t bus // Byte bus.
);
    timeunit 1ns;
    timeprecision 100ps;
    import crg_pkg::*;
    // Both ports idle from time zero.
    initial begin
        req = '0;
        bus = '0;
    end
    // Holds one request across one edge, then idles.
    task automatic issue(input crg_req_t r);
        @(posedge clk);
        #1;
        req = r;
        @(posedge clk);
        #1;
        req = '0;
    endtask : issue
    // One transfer; a word transfer is made only when asked for.
    task automatic special_function_region(input logic we, input logic [15:0] a, input logic [7:0] w,
        input logic whole, output logic [7:0] rd, output logic err);
        @(posedge clk);
        #1;
        bus = '{1'b1, we, !whole, a, w};
        @(posedge clk);
        #1;
        rd = bus_rdata;
        err = bus_err;
        bus = '0;
    endtask : special_function_region
endmodule : crg_seq_model

/* File: verification/testbench.sv */
// Self-checking testbench of the CPU register set.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import crg_pkg::*;
    logic clk = 1'b0;
    logic rst;
    logic nmi;
    logic [7:0] irq_ext;
    crg_req_t req;
    crg_req_t r;
    crg_bus_t bus;
    logic [15:0] rd_data, pc, sp, sr;
    logic [7:0] bus_rdata;
    logic bus_err, halted, irq_pending;
    logic [7:0] irq_pin;
    logic [1:0] clk_sel;
    logic osc_off;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    crg_seq_model i_crg_seq_model (.clk(clk), .bus_rdata(bus_rdata), .bus_err(bus_err),
        .req(req), .bus(bus));
    crg_core i_crg_core (.clk(clk), .rst(rst), .req(req), .bus(bus), .nmi(nmi),
        .irq_ext(irq_ext), .irq_ext_pin(irq_pin), .rd_data(rd_data), .program_counter(pc),
        .stack_pointer(sp), .status_register(sr), .stack_addr(), .alu_result(),
        .bus_rdata(bus_rdata), .bus_err(bus_err), .clockgen_sel(clk_sel), .cpu_halted(halted),
        .osc_stopped(osc_off), .irq_pending(irq_pending));
    // Clock of 4 ns period.
    always #2 clk = ~clk;
    // Cycle ceiling that cuts a hung run short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end
    // Compares one value and counts the outcome.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Register write and read helpers.
    task automatic wr(input logic [3:0] idx, input logic [15:0] d);
        r = '0;
        r.wr_en = 1'b1;
        r.wr_idx = idx;
        r.wr_data = d;
        i_crg_seq_model.issue(r);
    endtask : wr
    task automatic rdc(input logic [3:0] idx, input logic [1:0] m, input logic [15:0] exp);
        r = '0;
        r.rd_idx = idx;
        r.source_mode_bits = m;
        i_crg_seq_model.issue(r);
        check(rd_data, exp);
    endtask : rdc
    // Reset values, stored bytes, empty offsets and a refused word transfer.
    task automatic t_sfr();
        logic [7:0] rd;
        logic err;
        for (int i = 0; i < 16; i++) begin
            i_crg_seq_model.special_function_region(1'b0, 16'(i), 8'h00, 1'b0, rd, err);
            check({7'h00, err, rd}, (i < 6) ? 16'h0000 : 16'h0100);
            i_crg_seq_model.special_function_region(1'b1, 16'(i), 8'hC0 + 8'(i), 1'b0, rd, err);
            i_crg_seq_model.special_function_region(1'b0, 16'(i), 8'h00, 1'b0, rd, err);
            check({7'h00, err, rd}, (i < 6) ? 16'h00C0 + 16'(i) : 16'h0100);
        end
        i_crg_seq_model.special_function_region(1'b1, SFR_ME_FIRST, 8'h11, 1'b1, rd, err);
        check({15'h0000, err}, 16'h0001);
        i_crg_seq_model.special_function_region(1'b0, SFR_ME_FIRST, 8'h00, 1'b0, rd, err);
        check({8'h00, rd}, 16'h00C4);
    endtask : t_sfr
    // Working registers, forced alignment and constant sources.
    task automatic t_regs();
        logic [15:0] k3 [4];
        k3 = '{CONST_ZERO, CONST_ONE, CONST_TWO, CONST_ALL_ONES};
        for (int i = 4; i < 16; i++) wr(4'(i), 16'hA000 + 16'(i));
        for (int i = 4; i < 16; i++) rdc(4'(i), 2'b00, 16'hA000 + 16'(i));
        wr(IDX_PROGRAM_COUNTER, 16'h1235);
        check(pc, 16'h1234);
        wr(IDX_STACK_POINTER, 16'h0401);
        check(sp, 16'h0400);
        wr(IDX_CONSTANT_SECOND, 16'h5555);
        for (int m = 0; m < 4; m++) rdc(IDX_CONSTANT_SECOND, 2'(m), k3[m]);
        rdc(IDX_STATUS_REGISTER, 2'b10, CONST_FOUR);
        rdc(IDX_STATUS_REGISTER, 2'b11, CONST_EIGHT);
    endtask : t_regs
    // Counter steps of one, two and three words.
    task automatic t_pc();
        logic [15:0] e;
        e = 16'h0100;
        wr(IDX_PROGRAM_COUNTER, e);
        for (int n = 1; n < 4; n++) begin
            r = '0;
            r.pc_advance = 1'b1;
            r.pc_len_words = 3'(n);
            i_crg_seq_model.issue(r);
            e = e + 16'(2 * n);
            check(pc, e);
        end
    endtask : t_pc
    // Push and pop, then the pointer pushed and popped into itself.
    task automatic t_stack();
        wr(IDX_STACK_POINTER, 16'h0400);
        r = '0;
        r.stk = CRG_STK_PUSH;
        i_crg_seq_model.issue(r);
        check(sp, 16'h03FE);
        r.stk = CRG_STK_POP;
        i_crg_seq_model.issue(r);
        check(sp, 16'h0400);
        r.stk = CRG_STK_PUSH;
        i_crg_seq_model.issue(r);
        check(sp, 16'h03FE);
        r = '0;
        r.stk = CRG_STK_POP;
        r.wr_en = 1'b1;
        r.wr_idx = IDX_STACK_POINTER;
        r.wr_data = 16'h03FE;
        i_crg_seq_model.issue(r);
        check(sp, 16'h03FE);
    endtask : t_stack
    // Additions, subtractions, a compare and a logic operation with their full flag sets, then an idle request.
    task automatic t_flags();
        logic [51:0] t [10] = '{{CRG_OP_ADD, 1'b0, 16'h7FFF, 16'h0001, 16'h0104},
            {CRG_OP_ADD, 1'b0, 16'h8000, 16'h8000, 16'h0103},
            {CRG_OP_ADD, 1'b0, 16'h0001, 16'h0002, 16'h0000},
            {CRG_OP_ADD, 1'b1, 16'h007F, 16'h0001, 16'h0104},
            {CRG_OP_ADD, 1'b1, 16'h00FF, 16'h0001, 16'h0003},
            {CRG_OP_ADDC, 1'b0, 16'h7FFE, 16'h0001, 16'h0104},
            {CRG_OP_LOGIC, 1'b0, 16'h8000, 16'h0000, 16'h0004},
            {CRG_OP_CMP, 1'b0, 16'h0005, 16'h0005, 16'h0003},
            {CRG_OP_SUBC, 1'b0, 16'h0000, 16'h0001, 16'h0004},
            {CRG_OP_SUB, 1'b0, 16'h7FFF, 16'hFFFF, 16'h0104}};
        foreach (t[i]) begin
            r = '0;
            r.op = crg_op_t'(t[i][51:49]);
            {r.byte_op, r.op_a, r.op_b} = t[i][48:16];
            i_crg_seq_model.issue(r);
            check(sr, t[i][15:0]);
        end
        // Carry taken from the inverted zero condition.
        r = '0;
        r.op = CRG_OP_LOGIC;
        r.op_a = 16'h0001;
        r.carry_from_not_zero = 1'b1;
        i_crg_seq_model.issue(r);
        check(sr, 16'h0001);
        i_crg_seq_model.issue('0);
        check(sr, 16'h0001);
    endtask : t_flags
    // Halt, masking, entry, return and the non-maskable request.
    task automatic t_irq();
        logic [7:0] rd;
        logic err;
        i_crg_seq_model.special_function_region(1'b1, SFR_IE_FIRST, 8'h01, 1'b0, rd, err);
        i_crg_seq_model.special_function_region(1'b1, SFR_IFG_FIRST, 8'h00, 1'b0, rd, err);
        wr(IDX_STATUS_REGISTER, 16'h0010);
        check({15'h0000, halted}, 16'h0001);
        irq_ext = 8'h01;
        irq_pin = 8'h02;
        @(posedge clk);
        #1;
        irq_ext = 8'h00;
        irq_pin = 8'h00;
        repeat (3) @(posedge clk);
        #1;
        check({14'h0000, halted, irq_pending}, 16'h0002);
        i_crg_seq_model.special_function_region(1'b0, SFR_IFG_FIRST, 8'h00, 1'b0, rd, err);
        check({7'h00, err, rd}, 16'h0003);
        wr(IDX_STATUS_REGISTER, 16'h0018);
        check({14'h0000, halted, irq_pending}, 16'h0001);
        @(posedge clk);
        #1;
        check({15'h0000, irq_pending}, 16'h0001);
        r = '0;
        r.irq_enter = 1'b1;
        i_crg_seq_model.issue(r);
        check({15'h0000, sr[SR_GIE]}, 16'h0000);
        r = '0;
        r.return_from_interrupt = 1'b1;
        i_crg_seq_model.issue(r);
        check({15'h0000, sr[SR_GIE]}, 16'h0001);
        wr(IDX_STATUS_REGISTER, 16'h00E0);
        @(posedge clk);
        #1;
        check({12'h000, clk_sel, osc_off, halted}, 16'h000F);
        nmi = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check({13'h0000, osc_off, halted, irq_pending}, 16'h0001);
        nmi = 1'b0;
    endtask : t_irq
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    // Reset for 16 cycles, then every scenario in turn.
    initial begin
        rst = 1'b1;
        nmi = 1'b0;
        irq_ext = 8'h00;
        irq_pin = 8'h00;
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        t_sfr();
        t_regs();
        t_pc();
        t_stack();
        t_flags();
        t_irq();
        report_and_stop();
    end
endmodule : testbench
